// ===== fan_pwm_params.svh
// Constants of the fan PWM controller: codes, counts and reset values
`ifndef FAN_PWM_PARAMS_SVH
`define FAN_PWM_PARAMS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CLK_MHZ 125
`define PWM_FREQ_HZ 30
`define RAMP_STEPS 128
`define PWM_STEP_CYCLES ((`CLK_MHZ * 1000000) / (`PWM_FREQ_HZ * `RAMP_STEPS))
`define STEP_W 16
`define CLEAR_TIME_NS 30000
`define CLEAR_CYCLES ((`CLEAR_TIME_NS * `CLK_MHZ + 999) / 1000)
`define CLEAR_W 12
`define STARTUP_PERIODS 8
`define MISS_PERIODS 32
`define PERIOD_CNT_W 6

// ****************************************
// Digitised levels
// ****************************************
`define LEVEL_W 8
`define DUTY_W 8
`define RAMP_W 7
`define LEVEL_LO_CODE 8'h40
`define LEVEL_HI_CODE 8'hC0
`define DUTY_FULL 8'h80
`define SHUTDOWN_THRESHOLD_CODE 8'h1A
`define RELEASE_THRESHOLD_CODE 8'h26

`endif

// ===== fan_pwm_pkg.sv
// Types shared by the fan PWM controller
`include "fan_pwm_params.svh"

package fan_pwm_pkg;

    typedef enum logic [1:0] {
        ST_SHUTDOWN,
        ST_START,
        ST_RUN,
        ST_LATCH
    } fan_state_e;

    typedef struct packed {
        logic [`LEVEL_W-1:0] control;
        logic [`LEVEL_W-1:0] min_speed;
    } level_s;

endpackage : fan_pwm_pkg

// ===== tach_pulse_detect.sv
// Tachometer pulse detector on the sense input
`timescale 1ns/10ps
`default_nettype none

module tach_pulse_detect (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sense_in,
    output logic pulse_out
);

    logic sense_prev_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sense_prev_r <= 1'b0;
        end else begin
            sense_prev_r <= sense_in;
        end
    end

    // One pulse per rising edge of the chopped current
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= sense_in & ~sense_prev_r;
        end
    end

endmodule : tach_pulse_detect

`default_nettype wire

// ===== fan_pwm_fault_controller.sv
// Fan PWM speed controller with start-up timer and fan fault latch
`timescale 1ns/10ps
`default_nettype none
`include "fan_pwm_params.svh"

module fan_pwm_fault_controller
    import fan_pwm_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `PWM_STEP_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [`LEVEL_W-1:0] control_level_in,
    input wire logic [`LEVEL_W-1:0] min_speed_in,
    input wire logic sense_in,
    output logic pwm_out,
    output logic fault_out,
    output logic fault_oe_out
);

    // ****************************************
    // Level capture and duty mapping
    // ****************************************
    level_s level_r;
    logic [`DUTY_W-1:0] ctrl_duty;
    logic [`DUTY_W-1:0] min_duty;
    logic [`DUTY_W-1:0] duty_eff;
    logic in_shutdown_zone;
    logic at_release;

    function automatic logic [`DUTY_W-1:0] level_to_duty(
        input logic [`LEVEL_W-1:0] lvl
    );
        logic [`DUTY_W-1:0] d;
        d = 8'h00;
        if (lvl >= `LEVEL_HI_CODE) begin
            d = `DUTY_FULL;
        end else if (lvl > `LEVEL_LO_CODE) begin
            d = lvl - `LEVEL_LO_CODE;
        end
        return d;
    endfunction : level_to_duty

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            // Reset to release level so power-on never sees a false shutdown
            level_r <= '{control: 8'h00,
                min_speed: `RELEASE_THRESHOLD_CODE};
        end else begin
            level_r.control <= control_level_in;
            level_r.min_speed <= min_speed_in;
        end
    end

    assign ctrl_duty = level_to_duty(level_r.control);
    assign min_duty = level_to_duty(level_r.min_speed);
    assign duty_eff = (ctrl_duty > min_duty) ? ctrl_duty : min_duty;
    assign in_shutdown_zone = level_r.min_speed <= `SHUTDOWN_THRESHOLD_CODE;
    assign at_release = level_r.min_speed >= `RELEASE_THRESHOLD_CODE;

    // ****************************************
    // PWM ramp divider
    // ****************************************
    logic [`STEP_W-1:0] step_cnt_r;
    logic [`RAMP_W-1:0] ramp_r;
    logic step_end;
    logic period_end;

    assign step_end = step_cnt_r == `STEP_W'(STEP_CYCLES - 1);
    assign period_end = step_end && (ramp_r == {`RAMP_W{1'b1}});

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            step_cnt_r <= '0;
        end else if (step_end) begin
            step_cnt_r <= '0;
        end else begin
            step_cnt_r <= step_cnt_r + 1'b1;
        end
    end

    // Ramp of 128 steps at 30 Hz gives the period
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ramp_r <= '0;
        end else if (step_end) begin
            ramp_r <= ramp_r + 1'b1;
        end
    end

    // ****************************************
    // Tach sensing
    // ****************************************
    logic tach_pulse;
    logic [`PERIOD_CNT_W-1:0] miss_cnt_r;
    logic [`PERIOD_CNT_W-1:0] start_cnt_r;
    logic timeout;
    logic start_done;

    tach_pulse_detect u_tach (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .sense_in(sense_in),
        .pulse_out(tach_pulse)
    );

    // ****************************************
    // Mode state machine
    // ****************************************
    fan_state_e state_r;
    fan_state_e state_nxt;
    logic retry_used_r;
    logic [`CLEAR_W-1:0] clear_cnt_r;
    logic clear_done;

    assign timeout = (state_r == ST_RUN) && period_end && !tach_pulse
        && (miss_cnt_r == `PERIOD_CNT_W'(`MISS_PERIODS - 1));
    assign start_done = period_end
        && (start_cnt_r == `PERIOD_CNT_W'(`STARTUP_PERIODS - 1));
    assign clear_done = in_shutdown_zone
        && (clear_cnt_r == `CLEAR_W'(`CLEAR_CYCLES - 1));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_SHUTDOWN: begin
                if (at_release) begin
                    state_nxt = ST_START;
                end
            end
            ST_START: begin
                if (in_shutdown_zone) begin
                    state_nxt = ST_SHUTDOWN;
                end else if (start_done) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (in_shutdown_zone) begin
                    state_nxt = ST_SHUTDOWN;
                end else if (timeout && !retry_used_r) begin
                    state_nxt = ST_START;
                end else if (timeout) begin
                    state_nxt = ST_LATCH;
                end
            end
            ST_LATCH: begin
                if (clear_done) begin
                    state_nxt = ST_SHUTDOWN;
                end
            end
            default: begin
                state_nxt = ST_SHUTDOWN;
            end
        endcase
    end

    // Power-on enters the start-up timer directly
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_START;
        end else begin
            state_r <= state_nxt;
        end
    end

    // A pulse in run proves the fan alive and re-arms the single retry
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            retry_used_r <= 1'b0;
        end else if (state_r == ST_SHUTDOWN) begin
            retry_used_r <= 1'b0;
        end else if (timeout) begin
            retry_used_r <= 1'b1;
        end else if (state_r == ST_RUN && tach_pulse) begin
            retry_used_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_r != state_nxt) begin
            start_cnt_r <= '0;
        end else if (state_r == ST_START && period_end) begin
            start_cnt_r <= start_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_r != ST_RUN || tach_pulse) begin
            miss_cnt_r <= '0;
        end else if (period_end) begin
            miss_cnt_r <= miss_cnt_r + 1'b1;
        end
    end

    // Short dips below the threshold must not clear a latched fault
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_r != ST_LATCH || !in_shutdown_zone) begin
            clear_cnt_r <= '0;
        end else if (!clear_done) begin
            clear_cnt_r <= clear_cnt_r + 1'b1;
        end
    end

    // ****************************************
    // Output drivers
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pwm_out <= 1'b0;
        end else begin
            case (state_r)
                ST_START: pwm_out <= 1'b1;
                ST_RUN: pwm_out <= {1'b0, ramp_r} < duty_eff;
                default: pwm_out <= 1'b0;
            endcase
        end
    end

    // Start-up drive counts as full duty and flags the fault pin too
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            fault_oe_out <= 1'b0;
        end else begin
            case (state_r)
                ST_LATCH: fault_oe_out <= 1'b1;
                ST_START: fault_oe_out <= 1'b1;
                ST_RUN: fault_oe_out <= duty_eff == `DUTY_FULL;
                default: fault_oe_out <= 1'b0;
            endcase
        end
    end

    // Open drain: pin level is always low, only the enable moves
    always_ff @(posedge clk_in) begin
        fault_out <= 1'b0;
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_shutdown_quiet;
        state_r == ST_SHUTDOWN |=> !pwm_out && !fault_oe_out;
    endproperty
    a_shutdown_quiet: assert property (p_shutdown_quiet)
        else $error("shutdown must release fault and stop pwm");

    property p_enter_shutdown;
        (state_r inside {ST_START, ST_RUN}) && in_shutdown_zone
            |=> state_r == ST_SHUTDOWN;
    endproperty
    a_enter_shutdown: assert property (p_enter_shutdown)
        else $error("shutdown not entered at threshold");

    property p_hysteresis;
        state_r == ST_SHUTDOWN && !at_release |=> state_r == ST_SHUTDOWN;
    endproperty
    a_hysteresis: assert property (p_hysteresis)
        else $error("shutdown left below release threshold");

    property p_release_start;
        state_r == ST_SHUTDOWN && at_release
            |=> state_r == ST_START ##1 pwm_out;
    endproperty
    a_release_start: assert property (p_release_start)
        else $error("start-up drive missing after shutdown exit");

    property p_retry_once;
        timeout && !retry_used_r && !in_shutdown_zone
            |=> state_r == ST_START && retry_used_r;
    endproperty
    a_retry_once: assert property (p_retry_once)
        else $error("first fan fault did not retrigger start-up");

    property p_latch;
        timeout && retry_used_r && !in_shutdown_zone
            |=> state_r == ST_LATCH ##1 fault_oe_out && !pwm_out;
    endproperty
    a_latch: assert property (p_latch)
        else $error("persistent fault did not latch");

    property p_latch_hold;
        state_r == ST_LATCH && !in_shutdown_zone |=> state_r == ST_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched fault released without clear");

    property p_full_fault;
        state_r == ST_RUN && duty_eff == `DUTY_FULL && !in_shutdown_zone
            && !timeout
            |=> fault_oe_out && pwm_out && state_r == ST_RUN;
    endproperty
    a_full_fault: assert property (p_full_fault)
        else $error("full duty must flag fault without latching");

    property p_floor;
        state_r == ST_RUN && ({1'b0, ramp_r} < min_duty) |=> pwm_out;
    endproperty
    a_floor: assert property (p_floor)
        else $error("pwm below minimum-speed duty");

    property p_open_drain;
        !fault_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("fault pin driven high");

    property p_pulse_rearm;
        state_r == ST_RUN && tach_pulse |=> miss_cnt_r == '0;
    endproperty
    a_pulse_rearm: assert property (p_pulse_rearm)
        else $error("tach pulse did not restart missing-pulse count");

endmodule : fan_pwm_fault_controller

`default_nettype wire

// ===== fan_motor_model.sv
// Behavioural fan motor and sense resistor seen from the sense input
`timescale 1ns/10ps
`default_nettype none

module fan_motor_model (
    input wire logic clk_in,
    input wire logic spin_in,
    output logic sense_out = 1'b0
);
    // ****************************************
    // Tach pulses
    // ****************************************
    int phase_r = 0;

    // A stalled rotor stops chopping the current, so the line sits low
    always @(negedge clk_in) begin
        phase_r <= (phase_r == 39) ? 0 : phase_r + 1;
        sense_out <= spin_in && (phase_r < 4);
    end
endmodule : fan_motor_model
`default_nettype wire

// ===== fan_pwm_fault_controller_test.sv
// Self-checking testbench of the fan PWM controller
`timescale 1ns/10ps
`default_nettype none
`include "fan_pwm_params.svh"

module fan_pwm_fault_controller_test;
    // ****************************************
    // Signals
    // ****************************************
    localparam int STEP = 2;
    localparam int PER = 128 * STEP;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [`LEVEL_W-1:0] control_level_in = 8'h40;
    logic [`LEVEL_W-1:0] min_speed_in = 8'h40;
    logic sense_in;
    logic pwm_out;
    logic fault_out;
    logic fault_oe_out;
    logic spin = 1'b1;
    logic [31:0] seed = 32'h00014DB8;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] ctl_tab [7] = '{8'h30, 8'h40, 8'h41, 8'h80, 8'hBF, 8'hC0,
        8'hFF};

    fan_pwm_fault_controller #(.STEP_CYCLES(STEP)) i_fan_pwm_fault_controller (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .control_level_in(control_level_in), .min_speed_in(min_speed_in),
        .sense_in(sense_in), .pwm_out(pwm_out), .fault_out(fault_out),
        .fault_oe_out(fault_oe_out));

    fan_motor_model i_fan_motor_model (
        .clk_in(clk_in), .spin_in(spin), .sense_out(sense_in));

    initial begin
        forever #4 clk_in = ~clk_in;
    end

    // ****************************************
    // Model and helpers
    // ****************************************
    function automatic int duty_of(input logic [7:0] lvl);
        if (lvl <= `LEVEL_LO_CODE) return 0;
        if (lvl >= `LEVEL_HI_CODE) return 128;
        return int'(lvl) - 'h40;
    endfunction : duty_of

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic settle(input int n);
        repeat (n) @(negedge clk_in);
    endtask : settle

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic cmp_pins(input logic ep, input logic eo, input string what);
        checks_done++;
        if (pwm_out !== ep || fault_oe_out !== eo || fault_out !== 1'b0) begin
            fails++;
            $display("MISMATCH t=%0t %s pwm=%b oe=%b", $time, what, pwm_out,
                fault_oe_out);
        end
    endtask : cmp_pins

    // Any window of one full period holds exactly one ramp sweep
    task automatic cmp_duty(input logic [7:0] c, input logic [7:0] m);
        int d;
        int n;
        d = duty_of(c) > duty_of(m) ? duty_of(c) : duty_of(m);
        n = 0;
        control_level_in = c;
        min_speed_in = m;
        settle(4);
        repeat (PER) begin
            @(negedge clk_in);
            if (pwm_out === 1'b1) n++;
        end
        checks_done++;
        if (n != d * STEP || fault_oe_out !== (d == 128)) begin
            fails++;
            $display("MISMATCH t=%0t duty c=%h m=%h high=%0d", $time, c, m, n);
        end
    endtask : cmp_duty

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            summarize();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        settle(5);
        rst_n_in = 1'b1;
        settle(3);
        cmp_pins(1'b1, 1'b1, "power-on start");
        settle(9 * PER);
        $display("start-up test done");
        foreach (ctl_tab[i]) cmp_duty(ctl_tab[i], 8'h40);
        cmp_duty(8'h50, 8'hA0);
        repeat (6) begin
            r = rnd();
            cmp_duty(r[7:0], {1'b0, r[14:8]} + 8'h26);
        end
        $display("duty test done");
        min_speed_in = `SHUTDOWN_THRESHOLD_CODE;
        settle(4);
        cmp_pins(1'b0, 1'b0, "shutdown");
        control_level_in = 8'hFF;
        min_speed_in = 8'h25;
        settle(PER);
        cmp_pins(1'b0, 1'b0, "hysteresis");
        min_speed_in = `RELEASE_THRESHOLD_CODE;
        settle(4);
        cmp_pins(1'b1, 1'b1, "release start");
        $display("shutdown test done");
        settle(9 * PER);
        control_level_in = 8'h80;
        min_speed_in = 8'h40;
        spin = 1'b0;
        settle(34 * PER);
        cmp_pins(1'b1, 1'b1, "single retry");
        settle(42 * PER);
        cmp_pins(1'b0, 1'b1, "latched");
        control_level_in = 8'hC0;
        min_speed_in = 8'h10;
        settle(100);
        min_speed_in = 8'h40;
        settle(PER);
        cmp_pins(1'b0, 1'b1, "short dip");
        spin = 1'b1;
        min_speed_in = 8'h10;
        settle(3760);
        cmp_pins(1'b0, 1'b0, "cleared");
        min_speed_in = 8'h40;
        settle(4);
        cmp_pins(1'b1, 1'b1, "restart");
        $display("fault test done");
        summarize();
    end
endmodule : fan_pwm_fault_controller_test
`default_nettype wire
